// File: rtl/sdmc_top.sv
// sdmc_top: mode control of a stereo dac, pin mode and 3-wire register mode
`timescale 1ns/100ps
module sdmc_top (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                hw_mode_pin,
  input  wire logic                format_select,
  input  wire logic                deemphasis_pin,
  input  wire logic                mute_pin,
  input  wire logic                port_latch,
  input  wire logic                port_bit_clock,
  input  wire logic                port_serial_data,
  input  wire logic                sample_clock,
  input  wire logic                clock_ratio_low,
  output logic [2:0]               audio_format_r,
  output logic                     filter_slow_r,
  output logic                     deemphasis_on_r,
  output logic [1:0]               deemphasis_rate_r,
  output sdmc_pkg::sdmc_osr_t      osr_select_r,
  output logic [7:0]               left_level_r,
  output logic [7:0]               right_level_r,
  output logic                     left_zero_force_r,
  output logic                     right_zero_force_r,
  output logic                     output_phase_invert_r,
  output logic                     common_flag_select_r,
  output logic                     flag_polarity_r,
  output logic                     reset_busy_r
);
  import sdmc_pkg::*;

  localparam int STEP_W = $clog2(FS_PER_STEP);
  localparam int RST_W  = $clog2(RESET_CYCLES) + 1;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [7:0] in_meta_r;
  logic [7:0] in_sync_r;
  logic [1:0] in_prev_r;
  logic       latch_s;
  logic       bclk_s;
  logic       data_s;
  logic       fs_s;
  logic       hw_s;
  logic       fmt_pin_s;
  logic       deemp_s;
  logic       mute_s;
  logic       bclk_rise;
  logic       fs_rise;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_meta_r <= 8'h01;
      in_sync_r <= 8'h01;
      in_prev_r <= 2'h0;
    end else begin
      in_meta_r <= {mute_pin, deemphasis_pin, format_select, hw_mode_pin,
                    sample_clock, port_serial_data, port_bit_clock, port_latch};
      in_sync_r <= in_meta_r;
      in_prev_r <= {in_sync_r[3], in_sync_r[1]};
    end
  end

  assign latch_s   = in_sync_r[0];
  assign bclk_s    = in_sync_r[1];
  assign data_s    = in_sync_r[2];
  assign fs_s      = in_sync_r[3];
  assign hw_s      = in_sync_r[4];
  assign fmt_pin_s = in_sync_r[5];
  assign deemp_s   = in_sync_r[6];
  assign mute_s    = in_sync_r[7];
  assign bclk_rise = bclk_s & ~in_prev_r[0];
  assign fs_rise   = fs_s & ~in_prev_r[1];

  // ****************************************
  // serial control port
  // ****************************************
  sdmc_port_t  port_state_r;
  sdmc_port_t  port_state_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [4:0]  bit_cnt_r;
  logic [4:0]  bit_cnt_nxt;
  logic        word_done;

  always_comb begin
    port_state_nxt = port_state_r;
    shift_nxt      = shift_r;
    bit_cnt_nxt    = bit_cnt_r;
    case (port_state_r)
      PORT_IDLE: begin
        if (!latch_s) begin
          port_state_nxt = PORT_SHIFT;
          bit_cnt_nxt    = 5'h00;
        end
      end
      PORT_SHIFT: begin
        if (latch_s) begin
          port_state_nxt = PORT_IDLE;
        end else if (bclk_rise && (bit_cnt_r < WORD_BITS)) begin
          shift_nxt   = {shift_r[14:0], data_s};
          bit_cnt_nxt = bit_cnt_r + 5'h01;
        end
      end
      default: begin
        port_state_nxt = PORT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_state_r <= PORT_IDLE;
      shift_r      <= 16'h0000;
      bit_cnt_r    <= 5'h00;
    end else begin
      port_state_r <= port_state_nxt;
      shift_r      <= shift_nxt;
      bit_cnt_r    <= bit_cnt_nxt;
    end
  end

  // ****************************************
  // index decode
  // ****************************************
  logic [6:0] wr_idx;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       hit_left;
  logic       hit_right;
  logic       hit_mute;
  logic       hit_chan;
  logic       hit_fmt;
  logic       hit_zf;
  logic       hit_any;
  logic       soft_reset_bit_go;

  assign word_done = (port_state_r == PORT_SHIFT) && latch_s && (bit_cnt_r == WORD_BITS);
  assign wr_idx    = shift_r[IDX_MSB:IDX_LSB];
  assign wr_data   = shift_r[DATA_MSB:0];
  assign wr_en     = word_done && !shift_r[WORD_MSB];
  assign hit_left  = wr_en && (wr_idx == IDX_LEFT_ATT);
  assign hit_right = wr_en && (wr_idx == IDX_RIGHT_ATT);
  assign hit_mute  = wr_en && (wr_idx == IDX_MUTE_OSR);
  assign hit_chan  = wr_en && (wr_idx == IDX_CHAN_DEEMP);
  assign hit_fmt   = wr_en && (wr_idx == IDX_FMT_FILT);
  assign hit_zf    = wr_en && (wr_idx == IDX_ZF_PHASE);
  assign hit_any   = hit_left | hit_right | hit_mute | hit_chan | hit_fmt | hit_zf;
  assign soft_reset_bit_go   = hit_mute && wr_data[SOFT_RESET_BIT_BIT];

  // ****************************************
  // mode registers
  // ****************************************
  logic [7:0] left_att_r;
  logic [7:0] right_att_r;
  logic [7:0] mute_ctl_r;
  logic [7:0] chan_ctl_r;
  logic [7:0] fmt_ctl_r;
  logic [7:0] zf_ctl_r;
  logic       regs_clear;

  assign regs_clear = sys_rst | soft_reset_bit_go;

  always_ff @(posedge clk) begin
    if (regs_clear) begin
      left_att_r  <= ATT_RESET;
      right_att_r <= ATT_RESET;
      mute_ctl_r  <= MUTE_OSR_RESET;
      chan_ctl_r  <= CHAN_RESET;
      fmt_ctl_r   <= FMT_RESET;
      zf_ctl_r    <= ZF_RESET;
    end else begin
      if (hit_left)  left_att_r  <= wr_data;
      if (hit_right) right_att_r <= wr_data;
      if (hit_mute)  mute_ctl_r  <= wr_data;
      if (hit_chan)  chan_ctl_r  <= wr_data;
      if (hit_fmt)   fmt_ctl_r   <= wr_data;
      if (hit_zf)    zf_ctl_r    <= wr_data;
    end
  end

  // ****************************************
  // reset sequence and step timing
  // ****************************************
  logic [RST_W-1:0]  rst_cnt_r;
  logic [STEP_W-1:0] fs_cnt_r;
  logic              step_tick_r;

  always_ff @(posedge clk) begin
    if (regs_clear) begin
      rst_cnt_r <= RST_W'(RESET_CYCLES);
    end else if (rst_cnt_r != '0) begin
      rst_cnt_r <= rst_cnt_r - RST_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fs_cnt_r    <= '0;
      step_tick_r <= 1'b0;
    end else begin
      fs_cnt_r    <= fs_rise ? fs_cnt_r + STEP_W'(1) : fs_cnt_r;
      step_tick_r <= fs_rise && (fs_cnt_r == STEP_W'(FS_PER_STEP - 1));
    end
  end

  // ****************************************
  // attenuators
  // ****************************************
  logic       left_mute;
  logic       right_mute;
  logic [7:0] left_code;
  logic [7:0] right_code;

  assign left_mute  = hw_s ? mute_s : mute_ctl_r[MUTE_L_BIT];
  assign right_mute = hw_s ? mute_s : mute_ctl_r[MUTE_R_BIT];
  assign left_code  = hw_s ? ATT_RESET : left_att_r;
  assign right_code = hw_s ? ATT_RESET : right_att_r;

  sdmc_atten_ramp u_left (
    .clk       (clk),
    .rst       (regs_clear),
    .step_tick (step_tick_r),
    .code      (left_code),
    .soft_mute (left_mute),
    .level_r   (left_level_r)
  );

  sdmc_atten_ramp u_right (
    .clk       (clk),
    .rst       (regs_clear),
    .step_tick (step_tick_r),
    .code      (right_code),
    .soft_mute (right_mute),
    .level_r   (right_level_r)
  );

  // ****************************************
  // mode outputs
  // ****************************************
  logic [2:0] fmt_nxt;
  sdmc_osr_t  osr_nxt;
  sdmc_osr_t  osr_sw;
  logic       over;

  assign fmt_nxt = hw_s ? (fmt_pin_s ? FMT_RJ16 : FMT_I2S) : fmt_ctl_r[FMT_MSB:FMT_LSB];
  assign over    = mute_ctl_r[OVER_BIT];
  assign osr_sw  = clock_ratio_low ? (over ? OSR_64X : OSR_32X) : (over ? OSR_128X : OSR_64X);
  assign osr_nxt = hw_s ? OSR_64X : osr_sw;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      audio_format_r        <= FMT_RESET[FMT_MSB:FMT_LSB];
      filter_slow_r         <= 1'b0;
      deemphasis_on_r       <= 1'b0;
      deemphasis_rate_r     <= DMF_441;
      osr_select_r          <= OSR_64X;
      left_zero_force_r     <= 1'b1;
      right_zero_force_r    <= 1'b1;
      output_phase_invert_r <= 1'b0;
      common_flag_select_r  <= 1'b0;
      flag_polarity_r       <= 1'b0;
      reset_busy_r          <= 1'b1;
    end else begin
      audio_format_r        <= fmt_nxt;
      osr_select_r          <= osr_nxt;
      filter_slow_r         <= !hw_s && fmt_ctl_r[FLT_BIT];
      deemphasis_on_r       <= hw_s ? deemp_s : chan_ctl_r[DEEMP_EN_BIT];
      deemphasis_rate_r     <= hw_s ? DMF_441 : chan_ctl_r[DMF_MSB:DMF_LSB];
      left_zero_force_r     <= (rst_cnt_r != '0) || (!hw_s && chan_ctl_r[DIS_L_BIT]);
      right_zero_force_r    <= (rst_cnt_r != '0) || (!hw_s && chan_ctl_r[DIS_R_BIT]);
      output_phase_invert_r <= !hw_s && zf_ctl_r[PHASE_BIT];
      common_flag_select_r  <= hw_s || zf_ctl_r[COMMON_BIT];
      flag_polarity_r       <= !hw_s && zf_ctl_r[POL_BIT];
      reset_busy_r          <= rst_cnt_r != '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_left_write: assert property (@(posedge clk) disable iff (sys_rst)
      hit_left |=> (left_att_r == $past(shift_r[7:0])))
    else $error("left attenuation not written");
  chk_unmapped_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (word_done && !hit_any) |=> $stable({left_att_r, right_att_r, mute_ctl_r, chan_ctl_r, fmt_ctl_r, zf_ctl_r}))
    else $error("unmatched write changed a register");
  chk_att_default: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |-> (left_att_r == ATT_RESET) && (right_att_r == ATT_RESET))
    else $error("attenuation not all ones after reset");
  chk_hw_format: assert property (@(posedge clk) disable iff (sys_rst)
      hw_s |=> (audio_format_r == ($past(fmt_pin_s) ? FMT_RJ16 : FMT_I2S)))
    else $error("pin format not applied");
  chk_hw_osr: assert property (@(posedge clk) disable iff (sys_rst) hw_s |=> (osr_select_r == OSR_64X))
    else $error("pin mode oversampling not 64x");
  chk_soft_reset_bit_reload: assert property (@(posedge clk) disable iff (sys_rst)
      soft_reset_bit_go |=> (fmt_ctl_r == FMT_RESET) && (left_att_r == ATT_RESET) ##1 reset_busy_r[*2])
    else $error("soft reset did not reload defaults");
  chk_disable_zero: assert property (@(posedge clk) disable iff (sys_rst)
      (!hw_s && chan_ctl_r[DIS_L_BIT]) |=> left_zero_force_r)
    else $error("disabled left channel not forced to zero");
  chk_deemph_pin: assert property (@(posedge clk) disable iff (sys_rst)
      hw_s |=> (deemphasis_on_r == $past(deemp_s)) && (deemphasis_rate_r == DMF_441))
    else $error("pin deemphasis not applied");
  chk_osr_high: assert property (@(posedge clk) disable iff (sys_rst)
      (!hw_s && !clock_ratio_low && over) |=> (osr_select_r == OSR_128X))
    else $error("over bit did not select 128x");
  cov_left_write: cover property (@(posedge clk) disable iff (sys_rst) hit_left);
  cov_soft_reset: cover property (@(posedge clk) disable iff (sys_rst) soft_reset_bit_go);
  cov_left_muted: cover property (@(posedge clk) disable iff (sys_rst) left_level_r == ATT_MUTE_CODE);
endmodule // sdmc_top

// File: common/sdmc_pkg.sv
// sdmc_pkg: register map, field positions, defaults and enums of the dac mode control
package sdmc_pkg;
  // ****************************************
  // control word layout
  // ****************************************
  localparam logic [4:0] WORD_BITS      = 5'h10;
  localparam int         WORD_MSB       = 15;
  localparam int         IDX_MSB        = 14;
  localparam int         IDX_LSB        = 8;
  localparam int         DATA_MSB       = 7;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [6:0] IDX_LEFT_ATT   = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATT  = 7'h11;
  localparam logic [6:0] IDX_MUTE_OSR   = 7'h12;
  localparam logic [6:0] IDX_CHAN_DEEMP = 7'h13;
  localparam logic [6:0] IDX_FMT_FILT   = 7'h14;
  localparam logic [6:0] IDX_ZF_PHASE   = 7'h16;

  // ****************************************
  // field positions
  // ****************************************
  localparam int         MUTE_L_BIT     = 0;
  localparam int         MUTE_R_BIT     = 1;
  localparam int         OVER_BIT       = 6;
  localparam int         SOFT_RESET_BIT_BIT       = 7;
  localparam int         DIS_L_BIT      = 0;
  localparam int         DIS_R_BIT      = 1;
  localparam int         DEEMP_EN_BIT   = 4;
  localparam int         DMF_LSB        = 5;
  localparam int         DMF_MSB        = 6;
  localparam int         FMT_LSB        = 0;
  localparam int         FMT_MSB        = 2;
  localparam int         FLT_BIT        = 5;
  localparam int         PHASE_BIT      = 0;
  localparam int         POL_BIT        = 1;
  localparam int         COMMON_BIT     = 2;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [7:0] ATT_RESET      = 8'hFF;
  localparam logic [7:0] ATT_MUTE_CODE  = 8'h80;
  localparam logic [7:0] MUTE_OSR_RESET = 8'h00;
  localparam logic [7:0] CHAN_RESET     = 8'h00;
  localparam logic [7:0] FMT_RESET      = 8'h05;
  localparam logic [7:0] ZF_RESET       = 8'h00;
  localparam logic [2:0] FMT_RJ16       = 3'h3;
  localparam logic [2:0] FMT_I2S        = 3'h4;
  localparam logic [1:0] DMF_441        = 2'h0;

  // ****************************************
  // timing counts
  // ****************************************
  localparam int         FS_PER_STEP    = 8;
  localparam int         RESET_CYCLES   = 1024;

  typedef enum logic [1:0] {OSR_32X, OSR_64X, OSR_128X} sdmc_osr_t;
  typedef enum logic {PORT_IDLE, PORT_SHIFT} sdmc_port_t;
endpackage

// File: rtl/sdmc_atten_ramp.sv
// sdmc_atten_ramp: one channel attenuator that steps toward its target level
`timescale 1ns/100ps
module sdmc_atten_ramp (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       step_tick,
  input  wire logic [7:0] code,
  input  wire logic       soft_mute,
  output logic      [7:0] level_r
);
  import sdmc_pkg::*;

  logic [7:0] target;

  assign target = (soft_mute || (code <= ATT_MUTE_CODE)) ? ATT_MUTE_CODE : code;

  always_ff @(posedge clk) begin
    if (rst) begin
      level_r <= ATT_RESET;
    end else if (step_tick && (level_r < target)) begin
      level_r <= level_r + 8'h01;
    end else if (step_tick && (level_r > target)) begin
      level_r <= level_r - 8'h01;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_step_gated: assert property (@(posedge clk) disable iff (rst) (!step_tick && !rst) |=> $stable(level_r))
    else $error("level moved without a step tick");
  chk_step_up_one: assert property (@(posedge clk) disable iff (rst)
      (step_tick && !rst && (level_r < target)) |=> (level_r == $past(level_r) + 8'h01))
    else $error("level did not rise by one step");
  chk_mute_floor: assert property (@(posedge clk) disable iff (rst) level_r >= ATT_MUTE_CODE)
    else $error("level fell below the mute code");
endmodule // sdmc_atten_ramp

// File: testbench/sdmc_host_model.sv
// sdmc_host_model: host controller driving the 3-wire control port
`timescale 1ns/100ps
module sdmc_host_model (
  output logic port_latch,
  output logic port_bit_clock,
  output logic port_serial_data
);
  // ****************************************
  // idle levels
  // ****************************************
  // latch idles high
  initial begin
    port_latch       = 1'b1;
    port_bit_clock   = 1'b0;
    port_serial_data = 1'b0;
  end

  // ****************************************
  // one framed write, bit clock 80 ns
  // ****************************************
  // framed word, msb first
  task automatic write_word(input logic [15:0] word);
    port_latch = 1'b0;
    #80;
    for (int i = 15; i >= 0; i--) begin
      port_serial_data = word[i];
      #40;
      port_bit_clock = 1'b1;
      #40;
      port_bit_clock = 1'b0;
    end
    #40;
    port_latch       = 1'b1;
    port_serial_data = ~word[0];
    #80;
  endtask
endmodule // sdmc_host_model

// File: testbench/tb.sv
// tb: self-checking bench of the dac mode control
`timescale 1ns/100ps
module tb;
  import sdmc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic             clk;
  logic             sys_rst;
  logic             hw_mode_pin;
  logic             format_select;
  logic             deemphasis_pin;
  logic             mute_pin;
  logic             sample_clock;
  logic             clock_ratio_low;
  wire logic        port_latch;
  wire logic        port_bit_clock;
  wire logic        port_serial_data;
  logic [2:0]       audio_format_r;
  logic             filter_slow_r;
  logic             deemphasis_on_r;
  logic [1:0]       deemphasis_rate_r;
  sdmc_osr_t        osr_select_r;
  logic [7:0]       left_level_r;
  logic [7:0]       right_level_r;
  logic             left_zero_force_r;
  logic             right_zero_force_r;
  logic             output_phase_invert_r;
  logic             common_flag_select_r;
  logic             flag_polarity_r;
  logic             reset_busy_r;
  wire logic [13:0] mode_w;
  int               errors;
  int               compares;

  // format, slow, deemph on, rate, osr, zero force l r, phase, common, polarity
  assign mode_w = {audio_format_r, filter_slow_r, deemphasis_on_r, deemphasis_rate_r, osr_select_r,
                   left_zero_force_r, right_zero_force_r, output_phase_invert_r, common_flag_select_r,
                   flag_polarity_r};

  sdmc_top i_sdmc_top (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .hw_mode_pin           (hw_mode_pin),
    .format_select         (format_select),
    .deemphasis_pin        (deemphasis_pin),
    .mute_pin              (mute_pin),
    .port_latch            (port_latch),
    .port_bit_clock        (port_bit_clock),
    .port_serial_data      (port_serial_data),
    .sample_clock          (sample_clock),
    .clock_ratio_low       (clock_ratio_low),
    .audio_format_r        (audio_format_r),
    .filter_slow_r         (filter_slow_r),
    .deemphasis_on_r       (deemphasis_on_r),
    .deemphasis_rate_r     (deemphasis_rate_r),
    .osr_select_r          (osr_select_r),
    .left_level_r          (left_level_r),
    .right_level_r         (right_level_r),
    .left_zero_force_r     (left_zero_force_r),
    .right_zero_force_r    (right_zero_force_r),
    .output_phase_invert_r (output_phase_invert_r),
    .common_flag_select_r  (common_flag_select_r),
    .flag_polarity_r       (flag_polarity_r),
    .reset_busy_r          (reset_busy_r)
  );

  sdmc_host_model i_sdmc_host_model (
    .port_latch       (port_latch),
    .port_bit_clock   (port_bit_clock),
    .port_serial_data (port_serial_data)
  );

  // ****************************************
  // clocks and watchdog
  // ****************************************
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  initial sample_clock = 1'b0;
  always #20 sample_clock = ~sample_clock;

  initial begin
    #400000;
    errors++;
    print_verdict;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [15:0] w);
    i_sdmc_host_model.write_word(w);
    repeat (10) @(negedge clk);
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (reset_busy_r !== 1'b0 && n < 1100) begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= 900 && n <= 1040), 16'h0001, "busy length");
  endtask

  task automatic ramp(input bit right, input logic [7:0] target);
    logic [7:0] prev;
    int         gap;
    int         steps;
    prev  = right ? right_level_r : left_level_r;
    steps = 0;
    while (prev !== target && steps < 200) begin
      gap = 0;
      while ((right ? right_level_r : left_level_r) === prev && gap < 300) begin
        @(negedge clk);
        gap++;
      end
      check(16'(right ? right_level_r : left_level_r), 16'(target > prev ? prev + 8'h01 : prev - 8'h01),
            "level step");
      if (steps > 0)
        check(16'(gap >= 60 && gap <= 68), 16'h0001, "step spacing");
      prev = right ? right_level_r : left_level_r;
      steps++;
    end
    repeat (80) @(negedge clk);
    check(16'(right ? right_level_r : left_level_r), 16'(target), "level settled");
  endtask

  // ****************************************
  // register rows
  // ****************************************
  localparam int NROW = 18;
  logic [29:0] rows [NROW] = '{
    {16'h1420, 14'b000_1_0_00_01_00_000}, {16'h1401, 14'b001_0_0_00_01_00_000},
    {16'h1402, 14'b010_0_0_00_01_00_000}, {16'h1403, 14'b011_0_0_00_01_00_000},
    {16'h1424, 14'b100_1_0_00_01_00_000}, {16'h1405, 14'b101_0_0_00_01_00_000},
    {16'h1311, 14'b101_0_1_00_01_10_000}, {16'h1332, 14'b101_0_1_01_01_01_000},
    {16'h1350, 14'b101_0_1_10_01_00_000}, {16'h1300, 14'b101_0_0_00_01_00_000},
    {16'h1240, 14'b101_0_0_00_10_00_000}, {16'h1601, 14'b101_0_0_00_10_00_100},
    {16'h1602, 14'b101_0_0_00_10_00_001}, {16'h1604, 14'b101_0_0_00_10_00_010},
    {16'h1600, 14'b101_0_0_00_10_00_000}, {16'h1524, 14'b101_0_0_00_10_00_000},
    {16'h9424, 14'b101_0_0_00_10_00_000}, {16'h7F24, 14'b101_0_0_00_10_00_000}
  };

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    sys_rst         = 1'b1;
    hw_mode_pin     = 1'b0;
    format_select   = 1'b0;
    deemphasis_pin  = 1'b0;
    mute_pin        = 1'b0;
    clock_ratio_low = 1'b0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check(16'(mode_w), 16'(14'b101_0_0_00_01_11_000), "reset mode");
    check({left_level_r, right_level_r}, 16'hFFFF, "reset levels");
    check(16'(reset_busy_r), 16'h0001, "reset busy");
    wait_ready;
    check(16'(mode_w), 16'(14'b101_0_0_00_01_00_000), "ready mode");
    for (int i = 0; i < NROW; i++) begin
      wr(rows[i][29:14]);
      check(16'(mode_w), 16'(rows[i][13:0]), "mode row");
    end
    clock_ratio_low = 1'b1;
    wr(16'h1240);
    check(16'(osr_select_r), 16'(OSR_64X), "osr low ratio set");
    wr(16'h1200);
    check(16'(osr_select_r), 16'(OSR_32X), "osr low ratio clear");
    clock_ratio_low = 1'b0;
    wr(16'h1200);
    check(16'(osr_select_r), 16'(OSR_64X), "osr high ratio clear");
    wr(16'h10FD);
    ramp(1'b0, 8'hFD);
    check(16'(right_level_r), 16'h00FF, "right untouched");
    wr(16'h1100);
    ramp(1'b1, 8'h80);
    wr(16'h1181);
    ramp(1'b1, 8'h81);
    wr(16'h1203);
    ramp(1'b0, 8'h80);
    check(16'(right_level_r), 16'h0080, "right soft mute");
    wr(16'h1200);
    ramp(1'b0, 8'hFD);
    check(16'(right_level_r), 16'h0081, "right soft unmute");
    wr(16'h1424);
    wr(16'h1280);
    check(16'(mode_w), 16'(14'b101_0_0_00_01_11_000), "soft reset mode");
    check({left_level_r, right_level_r}, 16'hFFFF, "soft reset levels");
    check(16'(reset_busy_r), 16'h0001, "soft reset busy");
    wait_ready;
    check(16'(mode_w), 16'(14'b101_0_0_00_01_00_000), "after soft reset");
    hw_mode_pin     = 1'b1;
    deemphasis_pin  = 1'b1;
    clock_ratio_low = 1'b1;
    repeat (10) @(negedge clk);
    check(16'(mode_w), 16'(14'b100_0_1_00_01_00_010), "pin i2s");
    format_select  = 1'b1;
    deemphasis_pin = 1'b0;
    repeat (10) @(negedge clk);
    check(16'(mode_w), 16'(14'b011_0_0_00_01_00_010), "pin rj16");
    mute_pin = 1'b1;
    ramp(1'b0, 8'h80);
    check(16'(right_level_r), 16'h0080, "pin mute right");
    mute_pin = 1'b0;
    ramp(1'b0, 8'hFF);
    print_verdict;
  end
endmodule // tb
